/* File: gco_pkg.sv */
// Constants, register map and carrier types of the pointer overlay path.
// Assumes one 100 MHz dot clock shared with the raster timing generator.
//
// Behaviour
// - Pointer pattern box is 32 pixels wide and up to 512 lines tall.
// - Pointer placed anywhere by programmable X and Y positions, single pixel steps.
// - Horizontal doubling shows each pattern pixel twice, covering 64 pixels.
// - Pattern is read from display memory at two bits per pixel.
// - Each line's pattern is fetched during the preceding horizontal retrace.
// - Fetch start address takes bits 2-17 from start value, bits 0-1 zero.
// - A line uses two addresses over four planes, skipping one byte after each.
// - Code bit 0 built from bytes F,E,B,A; bit 1 from H,G,D,C.
// - Pattern addressing ignores odd/even or shift-4 memory organisation.
// - After the Y-position line the fetch pointer advances by 2 per line.
// - Pointer stops once middle 8 pointer bits equal the end address.
// - Line double scanning never repeats pointer lines.
// - The two-bit pattern can be driven on two status outputs.
// - Replacement mode 0 keeps the pointer off the pixels, which pass unmodified; the pattern can still drive the status outputs.
// - Replacement mode 1 alters only pixel bits selected by the plane mask.
// - Mode 1 code 00 leaves masked bits, code 01 inverts them.
// - Mode 1 code 10 substitutes colour 0, code 11 colour 1.
// - A setting chooses pattern or constant zero on the status outputs.
// - Pointer shown steadily or blinking at 16 or 32 frame phases.
// - Blanking with forcing enabled gives the default colour on the same edge.
// - Software screen-off hands all memory cycles to the host processor.
// - Anti-aliased font: plane 2 bit and plane 3 bit drive top outputs.
// - Anti-aliased font: lower six outputs come from the attribute logic.
// - Font code 00 is background, 01, 10 and 11 are foreground.
// - Character blink and text cursor keep working in anti-aliased font mode.
package gco_pkg;

    // ****************************************
    // Register offsets (APB byte addresses)
    // ****************************************
    localparam logic [7:0] OFS_MODE = 8'h00;
    localparam logic [7:0] OFS_XPOS = 8'h04;
    localparam logic [7:0] OFS_YPOS = 8'h08;
    localparam logic [7:0] OFS_START = 8'h0C;
    localparam logic [7:0] OFS_END = 8'h10;
    localparam logic [7:0] OFS_MASK = 8'h14;
    localparam logic [7:0] OFS_COLOR0 = 8'h18;
    localparam logic [7:0] OFS_COLOR1 = 8'h1C;
    localparam logic [7:0] OFS_DEFCOL = 8'h20;
    localparam logic [7:0] OFS_STATUS = 8'h24;

    // ****************************************
    // Mode register fields and reset values
    // ****************************************
    localparam int MODE_REPL_BIT = 0;
    localparam int MODE_STAT_BIT = 1;
    localparam int MODE_BLINK_LSB = 2;
    localparam int MODE_HDBL_BIT = 4;
    localparam int MODE_DEFC_BIT = 5;
    localparam int MODE_OFF_BIT = 6;
    localparam int MODE_AA_BIT = 7;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [10:0] XPOS_RST = 11'h000;
    localparam logic [9:0] YPOS_RST = 10'h000;
    localparam logic [15:0] START_RST = 16'h0000;
    localparam logic [7:0] END_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'hFF;
    localparam logic [7:0] COLOR_RST = 8'h00;

    // Blink selections
    localparam logic [1:0] BLINK_STEADY = 2'h0;
    localparam logic [1:0] BLINK_16 = 2'h1;
    localparam logic [1:0] BLINK_32 = 2'h2;

    // ****************************************
    // Pattern geometry and addressing
    // ****************************************
    localparam int PAT_W = 32;
    localparam logic [5:0] SPAN_LAST_1X = 6'h1F;
    localparam logic [5:0] SPAN_LAST_2X = 6'h3F;
    localparam logic [8:0] ROWS_LAST = 9'h1FF;
    localparam logic [16:0] PTR_STEP = 17'h00002;
    localparam logic [16:0] PTR_SKIP = 17'h00001;
    localparam int MID_LSB = 4;

    // Fetch sequencer, Gray coded along the usual path
    typedef enum logic [1:0] {
        GCO_IDLE = 2'b00,
        GCO_RD_LO = 2'b01,
        GCO_RD_HI = 2'b11,
        GCO_LOAD = 2'b10
    } gco_state_t;

    // Raster timing from the CRT controller
    typedef struct packed {
        logic frame_start;
        logic hretrace_start;
        logic de;
        logic blank;
    } gco_timing_t;

    // Video word to the palette DAC; bit 7 first
    typedef struct packed {
        logic font_code_lsb_out;
        logic font_code_msb_out;
        logic [5:0] attr_pixel_low_bits;
    } gco_video_t;

endpackage

/* File: gco_cursor_overlay.sv */
// Pointer fetch, overlay and default-colour path, with its APB register file.
// Assumes timing, pixel sources and the memory arbiter all run on pclk.
`timescale 1ns/100ps

module gco_cursor_overlay (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Raster timing
    input wire gco_pkg::gco_timing_t timing_in,
    // Pixel sources
    input wire logic [7:0] gfx_pixel_in,
    input wire logic [5:0] attr_pixel_low_bits,
    input wire logic font_plane2_bit,
    input wire logic font_plane3_bit,
    // Display memory fetch port
    output logic mem_req,
    output logic [17:0] mem_addr,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata,
    // Palette DAC side
    output gco_pkg::gco_video_t video_out,
    output logic [1:0] cursor_status,
    // Arbiter and attribute controls
    output logic host_owns_memory,
    output logic font_foreground
);

    // ****************************************
    // Functions
    // ****************************************

    // Known register offsets
    function automatic logic ofs_valid(input logic [7:0] a);
        case (a)
            gco_pkg::OFS_MODE, gco_pkg::OFS_XPOS, gco_pkg::OFS_YPOS,
            gco_pkg::OFS_START, gco_pkg::OFS_END, gco_pkg::OFS_MASK,
            gco_pkg::OFS_COLOR0, gco_pkg::OFS_COLOR1, gco_pkg::OFS_DEFCOL,
            gco_pkg::OFS_STATUS: ofs_valid = 1'b1;
            default: ofs_valid = 1'b0;
        endcase
    endfunction

    // Middle eight bits of the byte address held in a 2-byte-unit pointer
    function automatic logic [7:0] ptr_mid(input logic [16:0] p);
        ptr_mid = p[gco_pkg::MID_LSB +: 8];
    endfunction

    // ****************************************
    // Register file
    // ****************************************
    logic [7:0] mode_q;
    logic [10:0] xpos_q;
    logic [9:0] ypos_q;
    logic [15:0] start_q;
    logic [7:0] end_q;
    logic [7:0] mask_q;
    logic [7:0] color0_q;
    logic [7:0] color1_q;
    logic [7:0] defcol_q;
    logic [31:0] prdata_q;
    logic apb_wr;
    logic apb_rd_setup;
    logic [31:0] status_word;

    // Decoded mode bits
    logic repl_on;
    logic stat_on;
    logic [1:0] blink_sel;
    logic hdbl_on;
    logic defc_on;
    logic screen_off;
    logic aa_on;

    // Internal state seen through the status register
    logic armed_q;
    logic line_valid_q;
    logic [16:0] ptr_q;
    logic [8:0] rows_q;
    gco_pkg::gco_state_t st_q;

    assign repl_on = mode_q[gco_pkg::MODE_REPL_BIT];
    assign stat_on = mode_q[gco_pkg::MODE_STAT_BIT];
    assign blink_sel = mode_q[gco_pkg::MODE_BLINK_LSB +: 2];
    assign hdbl_on = mode_q[gco_pkg::MODE_HDBL_BIT];
    assign defc_on = mode_q[gco_pkg::MODE_DEFC_BIT];
    assign screen_off = mode_q[gco_pkg::MODE_OFF_BIT];
    assign aa_on = mode_q[gco_pkg::MODE_AA_BIT];

    // Zero-wait slave; an unknown offset errors and writes nothing
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~ofs_valid(paddr);
    assign apb_wr = psel & penable & pwrite & ofs_valid(paddr);
    assign apb_rd_setup = psel & ~penable & ~pwrite;
    assign prdata = prdata_q;

    assign status_word = {1'b0, rows_q, st_q, line_valid_q, armed_q, 1'b0, ptr_q};

    // Software-written registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= gco_pkg::MODE_RST;
            xpos_q <= gco_pkg::XPOS_RST;
            ypos_q <= gco_pkg::YPOS_RST;
            start_q <= gco_pkg::START_RST;
            end_q <= gco_pkg::END_RST;
            mask_q <= gco_pkg::MASK_RST;
            color0_q <= gco_pkg::COLOR_RST;
            color1_q <= gco_pkg::COLOR_RST;
            defcol_q <= gco_pkg::COLOR_RST;
        end else if (apb_wr) begin
            case (paddr)
                gco_pkg::OFS_MODE: mode_q <= pwdata[7:0];
                gco_pkg::OFS_XPOS: xpos_q <= pwdata[10:0];
                gco_pkg::OFS_YPOS: ypos_q <= pwdata[9:0];
                gco_pkg::OFS_START: start_q <= pwdata[15:0];
                gco_pkg::OFS_END: end_q <= pwdata[7:0];
                gco_pkg::OFS_MASK: mask_q <= pwdata[7:0];
                gco_pkg::OFS_COLOR0: color0_q <= pwdata[7:0];
                gco_pkg::OFS_COLOR1: color1_q <= pwdata[7:0];
                gco_pkg::OFS_DEFCOL: defcol_q <= pwdata[7:0];
                default: mode_q <= mode_q;
            endcase
        end
    end

    // Read data captured in the setup cycle so it comes from a flip-flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (apb_rd_setup) begin
            case (paddr)
                gco_pkg::OFS_MODE: prdata_q <= {24'h0, mode_q};
                gco_pkg::OFS_XPOS: prdata_q <= {21'h0, xpos_q};
                gco_pkg::OFS_YPOS: prdata_q <= {22'h0, ypos_q};
                gco_pkg::OFS_START: prdata_q <= {16'h0, start_q};
                gco_pkg::OFS_END: prdata_q <= {24'h0, end_q};
                gco_pkg::OFS_MASK: prdata_q <= {24'h0, mask_q};
                gco_pkg::OFS_COLOR0: prdata_q <= {24'h0, color0_q};
                gco_pkg::OFS_COLOR1: prdata_q <= {24'h0, color1_q};
                gco_pkg::OFS_DEFCOL: prdata_q <= {24'h0, defcol_q};
                gco_pkg::OFS_STATUS: prdata_q <= status_word;
                default: prdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // ****************************************
    // Vertical tracking of the pointer
    // ****************************************
    logic [9:0] next_line_q;
    logic arm_d;
    logic [16:0] ptr_d;
    logic [8:0] rows_d;
    logic fetch_go_q;

    // Next pointer state at each retrace; lines are physical scan lines,
    // so a double-scanned display row still gets a fresh pointer line
    always_comb begin
        arm_d = armed_q;
        ptr_d = ptr_q;
        rows_d = rows_q;
        if (next_line_q == ypos_q) begin
            arm_d = 1'b1;
            ptr_d = {start_q, 1'b0};
            rows_d = 9'h000;
        end else if (armed_q) begin
            ptr_d = ptr_q + gco_pkg::PTR_STEP;
            rows_d = rows_q + 9'h001;
            if (ptr_mid(ptr_d) == end_q || rows_q == gco_pkg::ROWS_LAST) begin
                arm_d = 1'b0;
            end
        end
    end

    // Line counter and fetch pointer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            next_line_q <= 10'h000;
            armed_q <= 1'b0;
            ptr_q <= 17'h00000;
            rows_q <= 9'h000;
            fetch_go_q <= 1'b0;
        end else if (timing_in.frame_start) begin
            next_line_q <= 10'h000;
            armed_q <= 1'b0;
            rows_q <= 9'h000;
            fetch_go_q <= 1'b0;
        end else if (timing_in.hretrace_start) begin
            next_line_q <= next_line_q + 10'h001;
            armed_q <= arm_d;
            ptr_q <= ptr_d;
            rows_q <= rows_d;
            fetch_go_q <= arm_d;
        end else begin
            fetch_go_q <= 1'b0;
        end
    end

    // ****************************************
    // Pattern fetch sequencer
    // ****************************************
    logic [31:0] lo_word_q;
    logic [31:0] pat0_q;
    logic [31:0] pat1_q;
    logic mem_req_q;
    logic [17:0] mem_addr_q;

    assign mem_req = mem_req_q;
    assign mem_addr = mem_addr_q;
    // Screen-off hands every memory cycle to the host
    assign host_owns_memory = screen_off;

    // Two reads per line at fixed physical addresses, whatever the memory
    // organisation; the byte after each used one is never touched
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= gco_pkg::GCO_IDLE;
            mem_req_q <= 1'b0;
            mem_addr_q <= 18'h00000;
            lo_word_q <= 32'h0000_0000;
            pat0_q <= 32'h0000_0000;
            pat1_q <= 32'h0000_0000;
            line_valid_q <= 1'b0;
        end else begin
            if (timing_in.hretrace_start) begin
                line_valid_q <= 1'b0;
            end
            case (st_q)
                gco_pkg::GCO_IDLE: begin
                    if (fetch_go_q && !screen_off) begin
                        mem_req_q <= 1'b1;
                        mem_addr_q <= {ptr_q, 1'b0};
                        st_q <= gco_pkg::GCO_RD_LO;
                    end
                end
                gco_pkg::GCO_RD_LO: begin
                    if (mem_ack) begin
                        lo_word_q <= mem_rdata;
                        mem_addr_q <= {ptr_q + gco_pkg::PTR_SKIP, 1'b0};
                        st_q <= gco_pkg::GCO_RD_HI;
                    end
                end
                gco_pkg::GCO_RD_HI: begin
                    if (mem_ack) begin
                        mem_req_q <= 1'b0;
                        // Bit 0: F,E,B,A; bit 1: H,G,D,C; first pixel at [0]
                        pat0_q <= {lo_word_q[7:0], lo_word_q[15:8],
                                   mem_rdata[7:0], mem_rdata[15:8]};
                        pat1_q <= {lo_word_q[23:16], lo_word_q[31:24],
                                   mem_rdata[23:16], mem_rdata[31:24]};
                        st_q <= gco_pkg::GCO_LOAD;
                    end
                end
                gco_pkg::GCO_LOAD: begin
                    line_valid_q <= 1'b1;
                    st_q <= gco_pkg::GCO_IDLE;
                end
                default: begin
                    mem_req_q <= 1'b0;
                    st_q <= gco_pkg::GCO_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // Horizontal placement and blink
    // ****************************************
    logic [10:0] hpix_q;
    logic span_on_q;
    logic [5:0] span_cnt_q;
    logic [5:0] frame_cnt_q;
    logic start_now;
    logic on_ptr;
    logic [5:0] cur_cnt;
    logic [5:0] span_last;
    logic [4:0] pat_idx;
    logic blink_vis;
    logic [1:0] ptr_code;

    assign start_now = timing_in.de & line_valid_q & (hpix_q == xpos_q);
    assign on_ptr = start_now | span_on_q;
    assign cur_cnt = start_now ? 6'h00 : span_cnt_q;
    assign span_last = hdbl_on ? gco_pkg::SPAN_LAST_2X : gco_pkg::SPAN_LAST_1X;
    assign pat_idx = hdbl_on ? cur_cnt[5:1] : cur_cnt[4:0];

    // Steady, or each visible or transparent phase lasts 16 or 32 frames
    always_comb begin
        case (blink_sel)
            gco_pkg::BLINK_16: blink_vis = ~frame_cnt_q[4];
            gco_pkg::BLINK_32: blink_vis = ~frame_cnt_q[5];
            default: blink_vis = 1'b1;
        endcase
    end

    // Pattern code of the current dot, zero when the pointer is absent
    assign ptr_code = (on_ptr && blink_vis) ? {pat1_q[pat_idx], pat0_q[pat_idx]} : 2'b00;

    // Pixel counter across the active line
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hpix_q <= 11'h000;
        end else if (timing_in.hretrace_start) begin
            hpix_q <= 11'h000;
        end else if (timing_in.de) begin
            hpix_q <= hpix_q + 11'h001;
        end
    end

    // Pointer span: 32 dots, or 64 when doubled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            span_on_q <= 1'b0;
            span_cnt_q <= 6'h00;
        end else if (timing_in.hretrace_start) begin
            span_on_q <= 1'b0;
            span_cnt_q <= 6'h00;
        end else if (timing_in.de && on_ptr) begin
            span_cnt_q <= cur_cnt + 6'h01;
            span_on_q <= (cur_cnt != span_last);
        end
    end

    // Frame counter for blinking
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_cnt_q <= 6'h00;
        end else if (timing_in.frame_start) begin
            frame_cnt_q <= frame_cnt_q + 6'h01;
        end
    end

    // ****************************************
    // Pixel path
    // ****************************************
    logic [7:0] base_px;
    logic [7:0] over_px;
    logic [7:0] repl_px;
    logic force_def;

    // Text attribute output already carries blink and text cursor effects,
    // so the anti-aliased mode only swaps in the two font planes on top
    assign base_px = aa_on ? {font_plane3_bit, font_plane2_bit, attr_pixel_low_bits}
                           : gfx_pixel_in;
    // Any non-zero font code is foreground to the attribute logic
    assign font_foreground = font_plane2_bit | font_plane3_bit;
    assign force_def = timing_in.blank & defc_on;

    // Replacement in mode 1; masked bits only
    always_comb begin
        case (ptr_code)
            2'b01: repl_px = ~base_px;
            2'b10: repl_px = color0_q;
            2'b11: repl_px = color1_q;
            default: repl_px = base_px;
        endcase
        if (repl_on) begin
            over_px = (repl_px & mask_q) | (base_px & ~mask_q);
        end else begin
            over_px = base_px;
        end
    end

    // Output registers; default colour and pointer land on the same edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            video_out <= '0;
            cursor_status <= 2'b00;
        end else begin
            video_out <= force_def ? defcol_q : over_px;
            cursor_status <= stat_on ? ptr_code : 2'b00;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    a_mode0_passthru: assert property (@(posedge pclk) disable iff (!presetn)
        (!repl_on && !force_def) |=> (video_out == $past(base_px)))
        else $error("mode 0 altered the pixel");

    a_invert_masked: assert property (@(posedge pclk) disable iff (!presetn)
        (repl_on && !force_def && ptr_code == 2'b01)
        |=> (video_out == ($past(base_px) ^ $past(mask_q))))
        else $error("code 01 did not invert masked bits");

    a_color_subst: assert property (@(posedge pclk) disable iff (!presetn)
        (repl_on && !force_def && ptr_code == 2'b11)
        |=> (video_out == (($past(color1_q) & $past(mask_q))
                           | ($past(base_px) & ~$past(mask_q)))))
        else $error("code 11 did not give colour 1");

    a_blank_default: assert property (@(posedge pclk) disable iff (!presetn)
        force_def |=> (video_out == $past(defcol_q)))
        else $error("blanking did not force default colour");

    a_status_off: assert property (@(posedge pclk) disable iff (!presetn)
        (!stat_on) ##1 (!stat_on) |-> (cursor_status == 2'b00))
        else $error("status pins not held at zero");

    a_host_fetch: assert property (@(posedge pclk) disable iff (!presetn)
        (screen_off && st_q == gco_pkg::GCO_IDLE) |=> !mem_req)
        else $error("fetch started during screen-off");

    a_fetch_start: assert property (@(posedge pclk) disable iff (!presetn)
        (st_q == gco_pkg::GCO_IDLE && fetch_go_q && !screen_off)
        |=> (mem_req && mem_addr == {$past(ptr_q), 1'b0} && mem_addr[1:0] == 2'b00))
        else $error("fetch address low bits not zero");

    a_ptr_step: assert property (@(posedge pclk) disable iff (!presetn)
        (timing_in.hretrace_start && !timing_in.frame_start && armed_q
         && next_line_q != ypos_q) |=> (ptr_q == $past(ptr_q) + 17'h00002))
        else $error("pointer did not advance by 2");

    a_second_word: assert property (@(posedge pclk) disable iff (!presetn)
        (st_q == gco_pkg::GCO_RD_LO && mem_ack)
        |=> (mem_addr == {ptr_q + 17'h00001, 1'b0}) && st_q == gco_pkg::GCO_RD_HI)
        else $error("second pattern word misaddressed");

    a_aa_font_bits: assert property (@(posedge pclk) disable iff (!presetn)
        (aa_on && !force_def && ptr_code == 2'b00)
        |=> (video_out.font_code_msb_out == $past(font_plane2_bit)
             && video_out.font_code_lsb_out == $past(font_plane3_bit)))
        else $error("font planes not on top outputs");

endmodule // gco_cursor_overlay

/* File: gco_mem_model.sv */
// Display memory responder for the pointer fetch port.
// Assumes one pclk domain; each word is answered after a short wait.
`timescale 1ns/100ps
module gco_mem_model #(
    parameter logic [31:0] PAT = 32'h0000FFFF,
    parameter logic [31:0] PAT_HI = 32'hFF00FF00
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Fetch port
    input wire logic mem_req,
    input wire logic [17:0] mem_addr,
    output logic mem_ack,
    output logic [31:0] mem_rdata
);
    logic [1:0] wait_q;
    // Slow on purpose, so the design must hold its request and address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_q <= 2'h0;
            mem_ack <= 1'b0;
        end else begin
            mem_ack <= mem_req && !mem_ack && wait_q == 2'h2;
            wait_q <= (mem_req && !mem_ack && wait_q != 2'h2) ? wait_q + 2'h1 : 2'h0;
        end
    end
    // Byte address bit 1 picks the second word of a line, so plane order shows;
    // inverted outside ack so stale data never matches
    assign mem_rdata = mem_ack ? (mem_addr[1] ? PAT_HI : PAT) : ~PAT;
endmodule // gco_mem_model

/* File: tb_top.sv */
// Self-checking bench for the pointer overlay path.
// Assumes the memory model answers the fetch port.
`timescale 1ns/100ps
module tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, mem_req, mem_ack;
    logic p2, p3, host_own, fg;
    logic [7:0] paddr, gfx;
    logic [5:0] attr;
    logic [31:0] pwdata, prdata, mem_rdata, rd;
    logic [17:0] mem_addr;
    logic [1:0] cstat;
    gco_pkg::gco_timing_t tim;
    gco_pkg::gco_video_t vid;
    int err_count, tests_run;
    gco_cursor_overlay u_gco_cursor_overlay (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .timing_in(tim), .gfx_pixel_in(gfx),
        .attr_pixel_low_bits(attr), .font_plane2_bit(p2), .font_plane3_bit(p3),
        .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
        .video_out(vid), .cursor_status(cstat), .host_owns_memory(host_own),
        .font_foreground(fg));
    gco_mem_model u_gco_mem_model (.pclk(pclk), .presetn(presetn), .mem_req(mem_req),
        .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
    // ****************************************
    // Bus tasks and comparison
    // ****************************************
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One APB transfer; request held until pready is seen high
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = w ? {31'h0, pslverr} : prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Drive pixel inputs for one dot, check the registered word after it
    task dot(input logic [7:0] g, input logic b, input logic [7:0] exp);
        @(posedge pclk);
        gfx <= g;
        tim.blank <= b;
        @(posedge pclk);
        #1 chk(vid, exp);
    endtask
    task wrap_up;
        $display("tests_run=%0d err_count=%0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        pclk = 0;
        forever #5 pclk = ~pclk;
    end
    // A hang far past the expected hundred or so cycles ends the run
    initial begin
        #100us;
        err_count++;
        wrap_up;
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, tim, gfx, attr, p2, p3} = '0;
        err_count = 0;
        tests_run = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        xfer(0, gco_pkg::OFS_MASK, 0); chk(rd, 32'hFF);
        xfer(1, 8'h40, 0); chk(rd, 1);
        dot(8'h3C, 0, 8'h3C);
        xfer(1, gco_pkg::OFS_DEFCOL, 32'h5A);
        xfer(1, gco_pkg::OFS_MODE, 32'h20);
        dot(8'h3C, 1, 8'h5A);
        xfer(1, gco_pkg::OFS_MODE, 32'h80);
        attr <= 6'h2A;
        for (int i = 0; i < 4; i++) begin
            p2 <= i[1];
            p3 <= i[0];
            dot(8'h00, 0, {i[0], i[1], 6'h2A});
            chk(fg, i != 0);
        end
        xfer(1, gco_pkg::OFS_MODE, 32'h40); #1 chk(host_own, 1);
        xfer(1, gco_pkg::OFS_START, 32'h0123);
        xfer(1, gco_pkg::OFS_END, 32'hFF);
        xfer(1, gco_pkg::OFS_MASK, 32'h0F);
        xfer(1, gco_pkg::OFS_COLOR1, 32'hA5);
        xfer(1, gco_pkg::OFS_MODE, 32'h03);
        @(posedge pclk) tim.frame_start <= 1'b1;
        @(posedge pclk) {tim.frame_start, tim.hretrace_start} <= 2'b01;
        @(posedge pclk) tim.hretrace_start <= 1'b0;
        for (int i = 0; i < 50 && mem_req !== 1'b1; i++) @(posedge pclk);
        chk(mem_addr, 18'h0048C);
        for (int i = 0; i < 50 && mem_ack !== 1'b1; i++) @(posedge pclk);
        @(posedge pclk);
        #1 chk(mem_addr, 18'h0048E);
        for (int i = 0; i < 50 && mem_req !== 1'b0; i++) @(posedge pclk);
        repeat (3) @(posedge pclk);
        tim.de <= 1'b1;
        dot(8'h3C, 0, 8'h35);
        chk(cstat, 2'b11);
        repeat (6) @(posedge pclk);
        dot(8'h3C, 0, 8'h3C);
        chk(cstat, 2'b00);
        repeat (6) @(posedge pclk);
        dot(8'h3C, 0, 8'h33);
        chk(cstat, 2'b01);
        wrap_up;
    end
endmodule // tb_top
